// ===== rtl/dcsw_pkg.sv
// Package: bit positions, codes and timing constants of the drive control/status words
package dcsw_pkg;
  localparam int WORD_W = 16;
  localparam int CLK_MHZ = 250;
  // Control word bit positions (fieldbus layout)
  localparam int CW_ON1 = 0;
  localparam int CW_ON2 = 1;
  localparam int CW_ON3 = 2;
  localparam int CW_NOCOAST = 3;
  localparam int CW_NOQSTOP = 4;
  localparam int CW_NOFREEZE = 5;
  localparam int CW_START = 6;
  localparam int CW_RESET = 7;
  localparam int CW_JOG1 = 8;
  localparam int CW_JOG2 = 9;
  localparam int CW_VALID = 10;
  localparam int CW_SLOW = 11;
  localparam int CW_CATCH = 12;
  // Status word bit positions
  localparam int SW_CTRL_RDY = 0;
  localparam int SW_DRV_RDY = 1;
  localparam int SW_NOCOAST = 2;
  localparam int SW_TRIP = 3;
  localparam int SW_OFF2 = 4;
  localparam int SW_OFF3 = 5;
  localparam int SW_START_DIS = 6;
  localparam int SW_WARN = 7;
  localparam int SW_SPEED_EQ = 8;
  localparam int SW_SERIAL = 9;
  localparam int SW_FREQ_OK = 10;
  localparam int SW_RUNNING = 11;
  localparam int SW_VOLT = 13;
  localparam int SW_CURR = 14;
  localparam int SW_THERM = 15;
  // Fast-I/O input placement
  localparam int FIO_N = 5;
  localparam int FIO_POS [FIO_N] = '{5, 12, 13, 14, 15};
  // Telegram profile code selecting fieldbus layout
  localparam logic [1:0] PROFILE_FIELDBUS = 2'h0;
  localparam logic [WORD_W-1:0] RESET_WORD = 16'h0000;
  // Fast-I/O response bound: 10 ms, well under it we refresh each cycle
  localparam int FIO_RESP_MS = 10;
  localparam int FIO_RESP_CYC = FIO_RESP_MS * CLK_MHZ * 1000;
  // Status path modes
  typedef enum logic [1:0] {
    DCSW_MODE_NATIVE = 2'b00,
    DCSW_MODE_FASTIO = 2'b01,
    DCSW_MODE_FIELDBUS = 2'b10
  } dcsw_mode_t;
  // Off-stage relay tracking
  typedef enum logic [1:0] {
    DCSW_OFF_IDLE = 2'b00,
    DCSW_OFF_STOPPING = 2'b01,
    DCSW_OFF_DONE = 2'b10
  } dcsw_off_t;
endpackage

// ===== rtl/dcsw_sync.sv
// Two-flop synchroniser bank for pin-level inputs
module dcsw_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  initial begin
    if (WIDTH < 1) $error("dcsw_sync: WIDTH must be positive");
  end

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // dcsw_sync

// ===== rtl/dcsw_top.sv
// Drive control word decoder and status word builder
module dcsw_top #(
  parameter int FREQ_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Command word from the bus master
  input wire logic [dcsw_pkg::WORD_W-1:0] fieldbus_control_word,
  input wire logic control_word_strobe,
  // Configuration
  input wire logic [1:0] telegram_profile,
  input wire logic fast_io_enable,
  input wire logic relay_off_stage_sel,
  input wire logic [FREQ_W-1:0] freq_low_limit,
  input wire logic [FREQ_W-1:0] freq_high_limit,
  input wire logic [FREQ_W-1:0] bus_jog1_freq,
  input wire logic [FREQ_W-1:0] bus_jog2_freq,
  input wire logic [FREQ_W-1:0] catch_slow_amount,
  input wire logic [FREQ_W-1:0] base_reference,
  // Drive conditions
  input wire logic [FREQ_W-1:0] output_freq,
  input wire logic [FREQ_W-1:0] motor_speed,
  input wire logic local_stop_key,
  input wire logic local_mode_sel,
  input wire logic start_signal,
  input wire logic drive_ready,
  input wire logic dc_volt_low,
  input wire logic dc_volt_high,
  input wire logic output_current_threshold,
  input wire logic over_temp_motor,
  input wire logic over_temp_drive,
  input wire logic thermistor_trip,
  input wire logic trip_active,
  input wire logic trip_lock,
  input wire logic warning_active,
  input wire logic [dcsw_pkg::FIO_N-1:0] digital_in,
  // Status words back to the master
  output logic [dcsw_pkg::WORD_W-1:0] fieldbus_status_word,
  output logic [dcsw_pkg::WORD_W-1:0] fast_io_status_word,
  // Commands to the drive
  output logic ramp_stop_cmd,
  output logic start_permit,
  output logic trip_reset_pulse,
  output logic off_stage_relay,
  output logic jog_active,
  output logic [FREQ_W-1:0] jog_freq,
  output logic [FREQ_W-1:0] speed_reference
);

  initial begin
    if (FREQ_W < 2) $error("dcsw_top: FREQ_W too small");
    for (int i = 0; i < dcsw_pkg::FIO_N; i++) begin
      if (dcsw_pkg::FIO_POS[i] >= dcsw_pkg::WORD_W) $error("dcsw_top: pin bit outside word");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: digital pins cross in from the outside world

  logic [dcsw_pkg::FIO_N-1:0] din_s;
  dcsw_sync #(.WIDTH(dcsw_pkg::FIO_N)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in(digital_in),
    .sync_out(din_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control word latch

  logic [dcsw_pkg::WORD_W-1:0] ctrl_q;
  logic [dcsw_pkg::WORD_W-1:0] ctrl_d;
  logic reset_bit_q;
  logic reset_bit_d;
  logic trip_rst_q;
  logic trip_rst_d;
  logic fieldbus_mode;

  // Latched word starts all-off so nothing runs before the master speaks
  always_comb begin
    ctrl_d = ctrl_q;
    reset_bit_d = reset_bit_q;
    trip_rst_d = 1'b0;
    if (control_word_strobe && fieldbus_control_word[dcsw_pkg::CW_VALID]) begin
      ctrl_d = fieldbus_control_word;
      reset_bit_d = fieldbus_control_word[dcsw_pkg::CW_RESET];
      trip_rst_d = fieldbus_control_word[dcsw_pkg::CW_RESET] & ~reset_bit_q;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= dcsw_pkg::RESET_WORD;
      reset_bit_q <= 1'b0;
      trip_rst_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      reset_bit_q <= reset_bit_d;
      trip_rst_q <= trip_rst_d;
    end
  end

  assign fieldbus_mode = (telegram_profile == dcsw_pkg::PROFILE_FIELDBUS);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and start-disable tracking

  logic off_all_on;
  logic off3_or_2;
  logic start_dis_q;
  logic start_dis_d;
  logic off_any_prev_q;
  logic off_any_prev_d;
  dcsw_pkg::dcsw_off_t off_q;
  dcsw_pkg::dcsw_off_t off_d;
  logic ramp_q;
  logic ramp_d;
  logic permit_q;
  logic permit_d;
  logic relay_q;
  logic relay_d;
  logic jog_q;
  logic jog_d;
  logic [FREQ_W-1:0] jogf_q;
  logic [FREQ_W-1:0] jogf_d;
  logic [FREQ_W-1:0] ref_q;
  logic [FREQ_W-1:0] ref_d;
  logic [FREQ_W:0] ref_up;

  assign off_all_on = ctrl_q[dcsw_pkg::CW_ON1] & ctrl_q[dcsw_pkg::CW_ON2]
                      & ctrl_q[dcsw_pkg::CW_ON3];
  assign off3_or_2 = ~ctrl_q[dcsw_pkg::CW_ON2] | ~ctrl_q[dcsw_pkg::CW_ON3];
  assign ref_up = {1'b0, base_reference} + {1'b0, catch_slow_amount};

  always_comb begin
    start_dis_d = start_dis_q;
    off_any_prev_d = off3_or_2;
    // Set wins over clear: new off stage or trip reset overrides the unlock
    if (fieldbus_mode && !ctrl_q[dcsw_pkg::CW_ON1] && ctrl_q[dcsw_pkg::CW_ON2]
        && ctrl_q[dcsw_pkg::CW_ON3] && ctrl_q[dcsw_pkg::CW_VALID]) begin
      start_dis_d = 1'b0;
    end
    if (trip_rst_q || (off3_or_2 && !off_any_prev_q)) begin
      start_dis_d = 1'b1;
    end
    ramp_d = fieldbus_mode ? ~off_all_on : ~ctrl_q[dcsw_pkg::CW_START];
    permit_d = (fieldbus_mode ? off_all_on & ~start_dis_q : 1'b1)
               & ctrl_q[dcsw_pkg::CW_START] & ~trip_active;
    off_d = off_q;
    case (off_q)
      dcsw_pkg::DCSW_OFF_IDLE:
        if (fieldbus_mode && !off_all_on) off_d = dcsw_pkg::DCSW_OFF_STOPPING;
      dcsw_pkg::DCSW_OFF_STOPPING:
        if (off_all_on) off_d = dcsw_pkg::DCSW_OFF_IDLE;
        else if (output_freq == '0) off_d = dcsw_pkg::DCSW_OFF_DONE;
      dcsw_pkg::DCSW_OFF_DONE:
        if (off_all_on || !fieldbus_mode) off_d = dcsw_pkg::DCSW_OFF_IDLE;
      default:
        off_d = dcsw_pkg::DCSW_OFF_IDLE;
    endcase
    // Relay only drives when configured; held until the off command lifts or the profile leaves fieldbus
    relay_d = relay_off_stage_sel && (off_d == dcsw_pkg::DCSW_OFF_DONE);
    jog_d = 1'b0;
    jogf_d = '0;
    if (fieldbus_mode && ctrl_q[dcsw_pkg::CW_JOG1]) begin
      jog_d = 1'b1;
      jogf_d = bus_jog1_freq;
    end else if (fieldbus_mode && ctrl_q[dcsw_pkg::CW_JOG2]) begin
      jog_d = 1'b1;
      jogf_d = bus_jog2_freq;
    end
    ref_d = base_reference;
    if (fieldbus_mode && ctrl_q[dcsw_pkg::CW_SLOW]) begin
      // Clamp at zero rather than wrap to a huge reference
      ref_d = (base_reference > catch_slow_amount) ?
              base_reference - catch_slow_amount : '0;
    end else if (fieldbus_mode && ctrl_q[dcsw_pkg::CW_CATCH]) begin
      ref_d = ref_up[FREQ_W] ? '1 : ref_up[FREQ_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      start_dis_q <= 1'b1;
      off_any_prev_q <= 1'b0;
      off_q <= dcsw_pkg::DCSW_OFF_IDLE;
      ramp_q <= 1'b1;
      permit_q <= 1'b0;
      relay_q <= 1'b0;
      jog_q <= 1'b0;
      jogf_q <= '0;
      ref_q <= '0;
    end else begin
      start_dis_q <= start_dis_d;
      off_any_prev_q <= off_any_prev_d;
      off_q <= off_d;
      ramp_q <= ramp_d;
      permit_q <= permit_d;
      relay_q <= relay_d;
      jog_q <= jog_d;
      jogf_q <= jogf_d;
      ref_q <= ref_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status words, rebuilt from live conditions every cycle

  logic [dcsw_pkg::WORD_W-1:0] fb_d;
  logic [dcsw_pkg::WORD_W-1:0] fb_q;
  logic [dcsw_pkg::WORD_W-1:0] fio_d;
  logic [dcsw_pkg::WORD_W-1:0] fio_q;
  logic [dcsw_pkg::WORD_W-1:0] common;
  logic [dcsw_pkg::WORD_W-1:0] pin_mask [dcsw_pkg::FIO_N];
  logic [dcsw_pkg::WORD_W-1:0] pin_slot [dcsw_pkg::FIO_N];

  // Raw pin levels, whatever function the inputs carry elsewhere
  for (genvar g = 0; g < dcsw_pkg::FIO_N; g++) begin : g_fio_pin
    assign pin_mask[g] = {{(dcsw_pkg::WORD_W-1){1'b0}}, 1'b1} << dcsw_pkg::FIO_POS[g];
    assign pin_slot[g] = din_s[g] ? pin_mask[g] : '0;
  end

  always_comb begin
    common = '0;
    common[dcsw_pkg::SW_CTRL_RDY] = drive_ready;
    common[dcsw_pkg::SW_DRV_RDY] = drive_ready & ~ctrl_q[dcsw_pkg::CW_NOCOAST];
    common[dcsw_pkg::SW_NOCOAST] = ctrl_q[dcsw_pkg::CW_NOCOAST];
    common[dcsw_pkg::SW_TRIP] = trip_active;
    common[dcsw_pkg::SW_START_DIS] = trip_lock;
    common[dcsw_pkg::SW_WARN] = warning_active;
    common[dcsw_pkg::SW_SPEED_EQ] = (motor_speed == ref_q);
    common[dcsw_pkg::SW_SERIAL] = ~(local_stop_key | local_mode_sel);
    common[dcsw_pkg::SW_FREQ_OK] = (output_freq > freq_low_limit)
                                   && (output_freq < freq_high_limit);
    common[dcsw_pkg::SW_RUNNING] = start_signal | (output_freq != '0);
    common[dcsw_pkg::SW_VOLT] = dc_volt_low | dc_volt_high;
    common[dcsw_pkg::SW_CURR] = output_current_threshold;
    common[dcsw_pkg::SW_THERM] = over_temp_motor | over_temp_drive
                                 | thermistor_trip;
    fb_d = common;
    if (fieldbus_mode) begin
      fb_d[dcsw_pkg::SW_CTRL_RDY] = off_all_on & drive_ready;
      fb_d[dcsw_pkg::SW_NOCOAST] = off_all_on & ctrl_q[dcsw_pkg::CW_NOCOAST]
                                   & ~trip_active;
      fb_d[dcsw_pkg::SW_OFF2] = ~ctrl_q[dcsw_pkg::CW_ON2];
      fb_d[dcsw_pkg::SW_OFF3] = ~ctrl_q[dcsw_pkg::CW_ON3];
      fb_d[dcsw_pkg::SW_START_DIS] = start_dis_q;
    end
    fio_d = fast_io_enable ? common : '0;
    for (int i = 0; i < dcsw_pkg::FIO_N; i++) begin
      // Refreshed each cycle: three cycles latency, far inside the bound
      if (fast_io_enable) begin
        fio_d = (fio_d & ~pin_mask[i]) | pin_slot[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fb_q <= dcsw_pkg::RESET_WORD;
      fio_q <= dcsw_pkg::RESET_WORD;
    end else begin
      fb_q <= fb_d;
      fio_q <= fio_d;
    end
  end

  assign fieldbus_status_word = fb_q;
  assign fast_io_status_word = fio_q;
  assign ramp_stop_cmd = ramp_q;
  assign start_permit = permit_q;
  assign trip_reset_pulse = trip_rst_q;
  assign off_stage_relay = relay_q;
  assign jog_active = jog_q;
  assign jog_freq = jogf_q;
  assign speed_reference = ref_q;
endmodule // dcsw_top

// ===== test/dcsw_master.sv
// Bus master model that issues control words to the drive
module dcsw_master (
  // Clock
  input wire logic mclk,
  // Control word path
  output logic [dcsw_pkg::WORD_W-1:0] fieldbus_control_word,
  output logic control_word_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fieldbus_control_word = 16'h0000;
    control_word_strobe = 1'b0;
  end
  // Word shows its inverse once released, so a late capture is caught
  task automatic send(input logic [15:0] w);
    @(posedge mclk);
    fieldbus_control_word <= w;
    control_word_strobe <= 1'b1;
    @(posedge mclk);
    control_word_strobe <= 1'b0;
    fieldbus_control_word <= ~w;
  endtask
endmodule // dcsw_master

// ===== test/dcsw_properties.sv
// Checker: port-level assertions for the control/status word block
module dcsw_checker #(
  parameter int FREQ_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Command side
  input wire logic [dcsw_pkg::WORD_W-1:0] fieldbus_control_word,
  input wire logic control_word_strobe,
  input wire logic [1:0] telegram_profile,
  input wire logic fast_io_enable,
  // Drive conditions
  input wire logic [FREQ_W-1:0] output_freq,
  input wire logic local_stop_key,
  input wire logic local_mode_sel,
  input wire logic start_signal,
  input wire logic dc_volt_low,
  input wire logic dc_volt_high,
  input wire logic output_current_threshold,
  input wire logic over_temp_motor,
  input wire logic over_temp_drive,
  input wire logic thermistor_trip,
  input wire logic [dcsw_pkg::FIO_N-1:0] digital_in,
  // Observed outputs
  input wire logic [dcsw_pkg::WORD_W-1:0] fieldbus_status_word,
  input wire logic [dcsw_pkg::WORD_W-1:0] fast_io_status_word,
  input wire logic trip_reset_pulse
);
  logic take;
  logic fb;
  assign take = control_word_strobe & fieldbus_control_word[dcsw_pkg::CW_VALID];
  assign fb = telegram_profile == dcsw_pkg::PROFILE_FIELDBUS;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // Live bits lag one edge; the first edge after reset still shows the reset zeros
  AST_SERIAL: assert property (
    $past(rstn) |-> fieldbus_status_word[9] == !$past(local_stop_key | local_mode_sel)
  ) else $error("serial permission bit wrong");
  AST_RUNNING: assert property (
    1'b1 |=> fieldbus_status_word[11] == $past(start_signal || output_freq != '0)
  ) else $error("running bit wrong");
  AST_VOLT: assert property (
    $past(rstn) |-> fieldbus_status_word[13] == $past(dc_volt_low | dc_volt_high)
  ) else $error("voltage warning bit wrong");
  AST_CURR: assert property (
    1'b1 |=> fieldbus_status_word[14] == $past(output_current_threshold)
  ) else $error("current limit bit wrong");
  AST_THERM: assert property (
    $past(rstn) |-> fieldbus_status_word[15]
      == $past(over_temp_motor | over_temp_drive | thermistor_trip)
  ) else $error("thermal bit wrong");
  AST_FAST_IO: assert property (
    (fast_io_enable && $stable(digital_in))[*5]
    |-> {fast_io_status_word[15:12], fast_io_status_word[5]} == digital_in
  ) else $error("fast io pin bits wrong");
  AST_TRIP_PULSE: assert property (
    trip_reset_pulse |-> $past(take & fieldbus_control_word[7])
  ) else $error("trip reset without request");
  AST_OFF_BITS: assert property (
    take && fb ##1 (!take && fb)[*3]
    |=> fieldbus_status_word[5:4] == ~$past(fieldbus_control_word[2:1], 4)
  ) else $error("off stage status bits wrong");
endmodule // dcsw_checker

bind dcsw_top dcsw_checker #(.FREQ_W(FREQ_W)) u_chk (
  .mclk, .rstn, .fieldbus_control_word, .control_word_strobe, .telegram_profile,
  .fast_io_enable, .output_freq, .local_stop_key, .local_mode_sel, .start_signal,
  .dc_volt_low, .dc_volt_high, .output_current_threshold, .over_temp_motor,
  .over_temp_drive, .thermistor_trip, .digital_in, .fieldbus_status_word,
  .fast_io_status_word, .trip_reset_pulse
);

// ===== test/dcsw_tb_top.sv
// Testbench: control/status word block against a reference model
module dcsw_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, control_word_strobe, local_stop_key, local_mode_sel, start_signal;
  logic drive_ready, dc_volt_low, dc_volt_high, output_current_threshold, over_temp_motor;
  logic over_temp_drive, thermistor_trip, trip_active, trip_lock, warning_active;
  logic ramp_stop_cmd, start_permit, trip_reset_pulse, off_stage_relay, jog_active, sd;
  logic [1:0] telegram_profile;
  logic [4:0] digital_in;
  logic [15:0] fieldbus_control_word, fieldbus_status_word, fast_io_status_word, jog_freq;
  logic [15:0] speed_reference, freq_low_limit, freq_high_limit, bus_jog1_freq, bus_jog2_freq;
  logic [15:0] catch_slow_amount, base_reference, output_freq, motor_speed;
  logic [15:0] sent[$];
  int failures, checks, pulses, npulse;
  logic fast_io_enable, relay_off_stage_sel;
  // Ignored word, start-disable clear and set, both jogs, slow, catch and both at once
  logic [15:0] m_words [8] = '{16'h0001, 16'h0406, 16'h0405, 16'h0577, 16'h0677, 16'h0C77,
    16'h1477, 16'h1C77};
  logic [15:0] t_words [3] = '{16'h0477, 16'h04F7, 16'h04F5};
  dcsw_master m (.mclk, .fieldbus_control_word, .control_word_strobe);
  dcsw_top #(.FREQ_W(16)) uut (
    .mclk, .rstn, .fieldbus_control_word, .control_word_strobe, .telegram_profile,
    .fast_io_enable, .relay_off_stage_sel, .freq_low_limit, .freq_high_limit,
    .bus_jog1_freq, .bus_jog2_freq, .catch_slow_amount, .base_reference, .output_freq,
    .motor_speed, .local_stop_key, .local_mode_sel, .start_signal, .drive_ready,
    .dc_volt_low, .dc_volt_high, .output_current_threshold, .over_temp_motor,
    .over_temp_drive, .thermistor_trip, .trip_active, .trip_lock, .warning_active,
    .digital_in, .fieldbus_status_word, .fast_io_status_word, .ramp_stop_cmd, .start_permit,
    .trip_reset_pulse, .off_stage_relay, .jog_active, .jog_freq, .speed_reference
  );
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) if (trip_reset_pulse === 1'b1) pulses++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Start-disable and trip reset are judged against the last accepted word only
  task automatic send_chk(input logic [15:0] w);
    logic [15:0] p;
    p = (sent.size() > 0) ? sent[$] : 16'h0000;
    m.send(w);
    if (w[10]) begin
      if ((p[1] && !w[1]) || (p[2] && !w[2]) || (w[7] && !p[7])) sd = 1'b1;
      else if (!w[0] && w[1] && w[2]) sd = 1'b0;
      if (w[7] && !p[7]) npulse++;
      sent.push_back(w);
    end
    p = sent[$];
    repeat (4) @(posedge mclk);
    #1;
    chk("ctrl status", fieldbus_status_word & 16'h0075, {9'h000, sd, !p[2], !p[1], 1'b0,
      &p[3:0] && !trip_active, 1'b0, &p[2:0] && drive_ready});
    chk("ramp stop", {15'h0000, ramp_stop_cmd}, {15'h0000, !(&p[2:0])});
    chk("start permit", {15'h0000, start_permit},
      {15'h0000, &p[2:0] && p[6] && !sd && !trip_active});
    chk("off relay", {15'h0000, off_stage_relay}, {15'h0000, !(&p[2:0])});
    chk("jog on", {15'h0000, jog_active}, {15'h0000, |p[9:8]});
    if (|p[9:8]) chk("jog freq", jog_freq, p[8] ? bus_jog1_freq : bus_jog2_freq);
    chk("speed ref", speed_reference, p[11] ? base_reference - catch_slow_amount :
      p[12] ? base_reference + catch_slow_amount : base_reference);
    chk("trip resets", 16'(pulses), 16'(npulse));
  endtask
  initial begin
    {rstn, local_stop_key, local_mode_sel, start_signal, dc_volt_low, dc_volt_high} = '0;
    {output_current_threshold, over_temp_motor, over_temp_drive, thermistor_trip} = '0;
    {trip_active, trip_lock, warning_active, digital_in, telegram_profile} = '0;
    {output_freq, motor_speed} = '0;
    drive_ready = 1'b1;
    {fast_io_enable, relay_off_stage_sel} = 2'h3;
    freq_low_limit = 16'h000A;
    freq_high_limit = 16'h001E;
    bus_jog1_freq = 16'h0123;
    bus_jog2_freq = 16'h0456;
    catch_slow_amount = 16'h0064;
    base_reference = 16'h03E8;
    {failures, checks, pulses, npulse} = '0;
    sd = 1'b1;
    void'($urandom(32'h4D2C));
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("power-up disable", fieldbus_status_word & 16'h0040, 16'h0040);
    send_chk(16'h047F);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      {local_stop_key, local_mode_sel, start_signal, dc_volt_low, dc_volt_high} <= 5'($urandom);
      {output_current_threshold, over_temp_motor, over_temp_drive} <= 3'($urandom);
      {thermistor_trip, trip_lock, warning_active} <= 3'($urandom);
      output_freq <= 16'($urandom_range(0, 40));
      motor_speed <= ($urandom & 1) ? base_reference : 16'($urandom);
      digital_in <= 5'($urandom);
      repeat (6) @(posedge mclk);
      #1;
      chk("upper status", fieldbus_status_word & 16'hEF00, {over_temp_motor | over_temp_drive
        | thermistor_trip, output_current_threshold, dc_volt_low | dc_volt_high, 1'b0,
        start_signal || output_freq != 0, output_freq > freq_low_limit && output_freq <
        freq_high_limit, !(local_stop_key || local_mode_sel), motor_speed == base_reference,
        8'h00});
      chk("fast io", fast_io_status_word & 16'hF020,
        {digital_in[4:1], 6'h00, digital_in[0], 5'h00});
    end
    @(posedge mclk);
    output_freq <= 16'h0000;
    for (int n = 0; n < 16; n++) send_chk(16'h0470 | 16'(n));
    foreach (m_words[k]) send_chk(m_words[k]);
    @(posedge mclk);
    trip_active <= 1'b1;
    foreach (t_words[k]) send_chk(t_words[k]);
    @(posedge mclk);
    relay_off_stage_sel <= 1'b0;
    fast_io_enable <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("relay unselected", {15'h0000, off_stage_relay}, 16'h0000);
    chk("fast io off", fast_io_status_word, 16'h0000);
    @(posedge mclk);
    telegram_profile <= 2'h1;
    trip_lock <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("native layout", fieldbus_status_word & 16'h0050, 16'h0000);
    tally_and_finish();
  end
  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end
endmodule // dcsw_tb_top
